/* File: shared/fcc_pkg.sv */
// package: register map, field positions, reset values and constants for flash clock/config
package fcc_pkg;
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFS_CLKDIV = 6'h00;
	localparam logic [5:0] OFS_CONFIG = 6'h01;
	localparam logic [5:0] OFS_SECHI = 6'h03;
	localparam logic [5:0] OFS_PROT = 6'h10;
	localparam logic [5:0] OFS_FLAGS = 6'h13;
	localparam int CLKDIV_LOADED_BIT = 7;
	localparam int CLKDIV_PRESCALE_BIT = 6;
	localparam int CLKDIV_DIV_MSB = 5;
	localparam int CFG_LOCK_BIT = 10;
	localparam int CFG_ACCESS_ERROR_IRQ_ENABLE_BIT = 8;
	localparam int CFG_BUFFER_EMPTY_IRQ_ENABLE_BIT = 7;
	localparam int CFG_COMPLETION_IRQ_ENABLE_BIT = 6;
	localparam int CFG_KEYW_BIT = 5;
	localparam int CFG_BLOCK_BIT = 1;
	localparam int CFG_BEN_BIT = 0;
	localparam int SECHI_BACKDOOR_ENABLE_BIT = 15;
	localparam int FLAG_COMMAND_COMPLETE_FLAG_BIT = 6;
	localparam int FLAG_COMMAND_BUFFER_EMPTY_FLAG_BIT = 7;
	localparam int FLAG_ACCESS_ERROR_FLAG_BIT = 4;
	localparam int PRESCALE_RATIO = 8;
	localparam logic [2:0] PRESCALE_LAST = 3'h7;
	localparam logic [15:0] BRANCH_SELF_OPCODE = 16'ha97f;
	localparam logic [5:0] DIV_RESET = 6'h00;
	localparam logic [15:0] PROT_RESET = 16'h0000;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
endpackage : fcc_pkg

/* File: rtl/fcc_clock_divider.sv */
// prescaler plus programmable divider making the flash timing clock tick
module fcc_clock_divider #(
	parameter int DIV_W = 6
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic osc_tick,
	input wire logic prescale_sel,
	input wire logic [DIV_W-1:0] div_value,
	output logic flash_tick
);
	logic [2:0] pre_count;
	logic [DIV_W-1:0] div_count;
	logic pre_out;
	logic div_wrap;

	// bypass or divide by eight
	assign pre_out = osc_tick && (!prescale_sel || pre_count == fcc_pkg::PRESCALE_LAST);
	// divide by value+1: wrap when count reaches value
	assign div_wrap = pre_out && (div_count >= div_value);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_count <= 3'h0;
			div_count <= '0;
			flash_tick <= 1'b0;
		end else if (clk_en) begin
			if (osc_tick) begin
				pre_count <= pre_count + 3'h1;
			end
			if (pre_out) begin
				div_count <= div_wrap ? '0 : div_count + 1'b1;
			end
			flash_tick <= div_wrap;
		end
	end
endmodule : fcc_clock_divider

/* File: rtl/fcc_flash_ctrl.sv */
// flash clock divider and configuration/control register block
//
// Function
// - timing clock comes from oscillator via prescaler then integer divider.
// - divider-loaded bit reads 1 after any divider write, never writable.
// - prescaler select 1 divides oscillator by eight, 0 passes it.
// - divider divides prescaler output by divide field plus one.
// - timing clock is re-timed into the bus clock domain.
// - reserved addresses ignore writes and read zero.
// - protection lock always readable, set-once in user mode, free in test.
// - protection lock set blocks writes to sector protection register.
// - access-error enable read/write; requests interrupt when flag set.
// - buffer-empty enable read/write; requests interrupt when flag set.
// - completion enable read/write; requests interrupt when flag set.
// - key-write mode readable, writable only with backdoor enable set.
// - key-write mode makes array writes keys, else program/erase starts.
// - branch lock set-once, reset clears, blocks branch enable writes.
// - branch enable returns branch-to-self opcode on busy array reads.
// - branch enable clear: busy read returns invalid data, no error.
// - sector protection readable always, writable only while unlocked.
// - backdoor enable reads 1 when backdoor key access allowed.
//
// Local design decision: the strobed register port.
module fcc_flash_ctrl #(
	parameter int DIV_W = 6,
	parameter int PROT_W = 16
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [fcc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	input wire logic osc_tick,
	input wire logic test_mode,
	input wire logic backdoor_enable,
	input wire logic [PROT_W-1:0] prot_reset_value,
	input wire logic access_error_flag,
	input wire logic command_buffer_empty_flag,
	input wire logic command_complete_flag,
	input wire logic array_busy,
	input wire logic array_read,
	input wire logic [15:0] array_rdata,
	output logic [15:0] core_rdata,
	input wire logic array_write,
	output logic array_key_write,
	output logic array_cmd_write,
	output logic flash_timing_clock,
	output logic access_error_irq,
	output logic buffer_empty_irq,
	output logic completion_irq,
	output logic [PROT_W-1:0] sector_protection
);
	logic divider_loaded_status;
	logic prescaler_select;
	logic [DIV_W-1:0] divide_value;
	logic protect_lock;
	logic access_error_irq_enable;
	logic buffer_empty_irq_enable;
	logic completion_irq_enable;
	logic key_write_mode;
	logic branch_in_place_lock;
	logic branch_in_place_enable;
	logic prot_loaded;
	logic flash_tick;
	logic tick_sync1;
	logic tick_sync2;
	logic sel_clkdiv;
	logic sel_config;
	logic sel_sechi;
	logic sel_prot;
	logic wr_clkdiv;
	logic wr_config;
	logic wr_prot;
	logic [15:0] next_rdata;
	logic [15:0] clkdiv_word;
	logic [15:0] config_word;
	logic [15:0] next_core_rdata;
	logic next_lock;

	function automatic logic hit(input logic [fcc_pkg::ADDR_W-1:0] a,
		input logic [fcc_pkg::ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	assign sel_clkdiv = hit(reg_addr, fcc_pkg::OFS_CLKDIV);
	assign sel_config = hit(reg_addr, fcc_pkg::OFS_CONFIG);
	assign sel_sechi = hit(reg_addr, fcc_pkg::OFS_SECHI);
	assign sel_prot = hit(reg_addr, fcc_pkg::OFS_PROT);
	// unmapped addresses decode to nothing, so writes there are lost
	assign wr_clkdiv = clk_en && reg_write && sel_clkdiv;
	assign wr_config = clk_en && reg_write && sel_config;
	assign wr_prot = clk_en && reg_write && sel_prot && !protect_lock;

	// user mode may only raise the lock; test mode may write either way
	assign next_lock = test_mode ? reg_wdata[fcc_pkg::CFG_LOCK_BIT]
		: (protect_lock | reg_wdata[fcc_pkg::CFG_LOCK_BIT]);

	fcc_clock_divider #(
		.DIV_W(DIV_W)
	) u_divider (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.osc_tick(osc_tick),
		.prescale_sel(prescaler_select),
		.div_value(divide_value),
		.flash_tick(flash_tick)
	);

	// divider registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			divider_loaded_status <= 1'b0;
			prescaler_select <= 1'b0;
			divide_value <= DIV_W'(fcc_pkg::DIV_RESET);
		end else if (wr_clkdiv) begin
			divider_loaded_status <= 1'b1;
			prescaler_select <= reg_wdata[fcc_pkg::CLKDIV_PRESCALE_BIT];
			divide_value <= reg_wdata[DIV_W-1:0];
		end
	end

	// configuration bits
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			protect_lock <= 1'b0;
			access_error_irq_enable <= 1'b0;
			buffer_empty_irq_enable <= 1'b0;
			completion_irq_enable <= 1'b0;
			key_write_mode <= 1'b0;
			branch_in_place_lock <= 1'b0;
			branch_in_place_enable <= 1'b0;
		end else if (wr_config) begin
			protect_lock <= next_lock;
			access_error_irq_enable <= reg_wdata[fcc_pkg::CFG_ACCESS_ERROR_IRQ_ENABLE_BIT];
			buffer_empty_irq_enable <= reg_wdata[fcc_pkg::CFG_BUFFER_EMPTY_IRQ_ENABLE_BIT];
			completion_irq_enable <= reg_wdata[fcc_pkg::CFG_COMPLETION_IRQ_ENABLE_BIT];
			if (backdoor_enable) begin
				key_write_mode <= reg_wdata[fcc_pkg::CFG_KEYW_BIT];
			end
			// set-once: only a one can land
			branch_in_place_lock <= branch_in_place_lock | reg_wdata[fcc_pkg::CFG_BLOCK_BIT];
			if (!branch_in_place_lock) begin
				branch_in_place_enable <= reg_wdata[fcc_pkg::CFG_BEN_BIT];
			end
		end
	end

	// protection word is caught from the strap once after reset release
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prot_loaded <= 1'b0;
			sector_protection <= PROT_W'(fcc_pkg::PROT_RESET);
		end else if (clk_en) begin
			if (!prot_loaded) begin
				prot_loaded <= 1'b1;
				sector_protection <= prot_reset_value;
			end else if (wr_prot) begin
				sector_protection <= reg_wdata[PROT_W-1:0];
			end
		end
	end

	// flash tick re-timed through two flops, then registered once more into flash_timing_clock
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_sync1 <= 1'b0;
			tick_sync2 <= 1'b0;
			flash_timing_clock <= 1'b0;
		end else if (clk_en) begin
			tick_sync1 <= flash_tick;
			tick_sync2 <= tick_sync1;
			flash_timing_clock <= tick_sync2;
		end
	end

	assign clkdiv_word = {8'h00, divider_loaded_status, prescaler_select,
		divide_value};
	assign config_word = {5'h00, protect_lock, 1'b0, access_error_irq_enable,
		buffer_empty_irq_enable, completion_irq_enable, key_write_mode, 3'h0,
		branch_in_place_lock, branch_in_place_enable};

	// reserved or unmapped offsets read zero
	assign next_rdata = sel_clkdiv ? clkdiv_word
		: sel_config ? config_word
		: sel_sechi ? {backdoor_enable, 15'h0000}
		: sel_prot ? 16'(sector_protection)
		: fcc_pkg::WORD_ZERO;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= fcc_pkg::WORD_ZERO;
		end else if (clk_en) begin
			reg_rdata <= reg_read ? next_rdata : fcc_pkg::WORD_ZERO;
		end
	end

	// busy reads: opcode when enabled, otherwise array output passed as-is
	// (invalid) with no error raised here
	assign next_core_rdata = (array_busy && branch_in_place_enable)
		? fcc_pkg::BRANCH_SELF_OPCODE : array_rdata;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			core_rdata <= fcc_pkg::WORD_ZERO;
		end else if (clk_en && array_read) begin
			core_rdata <= next_core_rdata;
		end
	end

	assign array_key_write = array_write && key_write_mode;
	assign array_cmd_write = array_write && !key_write_mode;

	assign access_error_irq = access_error_irq_enable && access_error_flag;
	assign buffer_empty_irq = buffer_empty_irq_enable && command_buffer_empty_flag;
	assign completion_irq = completion_irq_enable && command_complete_flag;
endmodule : fcc_flash_ctrl

/* File: test/fcc_osc_model.sv */
// oscillator model: one tick pulse every OSC_PERIOD bus clocks
module fcc_osc_model #(
	parameter int OSC_PERIOD = 3
) (
	input wire logic clk,
	input wire logic reset_n,
	output logic osc_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 0;
			osc_tick <= 1'b0;
		end else begin
			osc_tick <= cnt == OSC_PERIOD - 1;
			cnt <= (cnt == OSC_PERIOD - 1) ? 0 : cnt + 1;
		end
	end
endmodule : fcc_osc_model

/* File: test/fcc_flash_ctrl_monitor.sv */
// checker: bus, array and interrupt relations of the flash config block
module fcc_flash_ctrl_monitor #(
	parameter int PROT_W = 16
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [fcc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] reg_rdata,
	input wire logic access_error_flag,
	input wire logic command_buffer_empty_flag,
	input wire logic command_complete_flag,
	input wire logic array_busy,
	input wire logic array_read,
	input wire logic [15:0] array_rdata,
	input wire logic [15:0] core_rdata,
	input wire logic array_write,
	input wire logic array_key_write,
	input wire logic array_cmd_write,
	input wire logic flash_timing_clock,
	input wire logic access_error_irq,
	input wire logic buffer_empty_irq,
	input wire logic completion_irq,
	input wire logic [PROT_W-1:0] sector_protection
);
	timeunit 1ns;
	timeprecision 1ns;
	wire mapped = reg_addr inside {fcc_pkg::OFS_CLKDIV, fcc_pkg::OFS_CONFIG,
		fcc_pkg::OFS_SECHI, fcc_pkg::OFS_PROT};
	wire prot_wr = reg_write && reg_addr == fcc_pkg::OFS_PROT;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_ae_irq: assert property (access_error_irq |-> access_error_flag)
		else $error("access error irq without flag");
	a_be_irq: assert property (buffer_empty_irq |-> command_buffer_empty_flag)
		else $error("buffer empty irq without flag");
	a_cc_irq: assert property (completion_irq |-> command_complete_flag)
		else $error("completion irq without flag");
	a_unmapped_zero: assert property ($past(reg_read && !mapped) |-> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_array_split: assert property (array_write |-> array_key_write != array_cmd_write)
		else $error("array write not routed once");
	a_array_quiet: assert property (!array_write |-> !array_key_write && !array_cmd_write)
		else $error("array strobe without write");
	a_core_pass: assert property ($past(array_read && !array_busy) |-> core_rdata == $past(array_rdata))
		else $error("idle array read not passed");
	a_prot_hold: assert property ($past(reset_n, 2) && !$past(prot_wr) |-> $stable(sector_protection))
		else $error("protection changed without write");
	a_tick_pulse: assert property (flash_timing_clock |=> !flash_timing_clock)
		else $error("timing clock pulse too long");
endmodule : fcc_flash_ctrl_monitor

bind fcc_flash_ctrl fcc_flash_ctrl_monitor #(.PROT_W(PROT_W)) mon (.*);

/* File: test/fcc_flash_ctrl_tb.sv */
// testbench: register bus, clock divider, locks and array paths
module fcc_flash_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int OSCP = 3;
	logic clk = 0, reset_n = 0, clk_en = 1, reg_write = 0, reg_read = 0, osc_tick;
	logic test_mode = 0, backdoor_enable = 0, array_busy = 0, array_read = 0, array_write = 0;
	logic access_error_flag = 0, command_buffer_empty_flag = 0, command_complete_flag = 0;
	logic [fcc_pkg::ADDR_W-1:0] reg_addr = 6'h00;
	logic [15:0] reg_wdata = 16'h0000, array_rdata = 16'h0000, prot_reset_value, v1, v2;
	logic [15:0] reg_rdata, core_rdata, sector_protection, seed = 16'h0062;
	logic array_key_write, array_cmd_write, flash_timing_clock;
	logic access_error_irq, buffer_empty_irq, completion_irq, rd_d = 0, ar_d = 0;
	logic [15:0] rq[$], cq[$];
	logic [5:0] un[5] = '{6'h02, 6'h04, 6'h11, 6'h13, 6'h3f};
	int mismatches = 0, checks_done = 0, cyc = 0;
	fcc_flash_ctrl dut (.*);
	fcc_osc_model #(.OSC_PERIOD(OSCP)) osc (.clk(clk), .reset_n(reset_n), .osc_tick(osc_tick));
	always #5 clk = ~clk;
	function automatic logic [15:0] lfsr();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction : lfsr
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		rq.push_back(e);
		@(posedge clk);
		reg_read <= 1'b0;
	endtask : rd
	task automatic arr_rd(input logic [15:0] d, input logic [15:0] e);
		@(posedge clk);
		array_read <= 1'b1;
		array_rdata <= d;
		cq.push_back(e);
		@(posedge clk);
		array_read <= 1'b0;
	endtask : arr_rd
	task automatic arr_wr(input logic [1:0] e);
		@(posedge clk);
		array_write <= 1'b1;
		#1 chk("key_cmd", 16'({array_key_write, array_cmd_write}), 16'(e));
		@(posedge clk);
		array_write <= 1'b0;
	endtask : arr_wr
	task automatic irq(input logic [2:0] e);
		@(posedge clk);
		#1 chk("irq", 16'({access_error_irq, buffer_empty_irq, completion_irq}), 16'(e));
	endtask : irq
	task automatic per(input logic p, input logic [5:0] d);
		int n = 0;
		wr(fcc_pkg::OFS_CLKDIV, {9'h000, p, d});
		repeat (2) @(posedge clk iff flash_timing_clock);
		do begin
			@(posedge clk);
			n++;
		end while (!flash_timing_clock);
		chk("period", 16'(n), 16'(OSCP * (p ? fcc_pkg::PRESCALE_RATIO : 1) * (d + 1)));
	endtask : per
	always @(posedge clk) begin
		if (rd_d) chk("reg_rdata", reg_rdata, rq.pop_front());
		if (ar_d) chk("core_rdata", core_rdata, cq.pop_front());
		rd_d <= reg_read;
		ar_d <= array_read;
		cyc++;
		// ceiling well above the fewer than one thousand cycles the sequence needs
		if (cyc == 20000) begin
			mismatches++;
			end_sim();
		end
	end
	initial begin
		prot_reset_value = lfsr();
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		// first enabled edge loads the protection strap
		@(posedge clk);
		rd(fcc_pkg::OFS_CLKDIV, 16'h0000);
		rd(fcc_pkg::OFS_PROT, prot_reset_value);
		// settings are chosen once for the slow model oscillator; none has a zero divide field
		wr(fcc_pkg::OFS_CLKDIV, 16'hff49);
		rd(fcc_pkg::OFS_CLKDIV, 16'h00c9);
		per(1'b0, 6'h01);
		per(1'b1, 6'h02);
		per(1'b0, 6'h3f);
		$display("divider test done");
		foreach (un[i]) begin
			wr(un[i], lfsr());
			rd(un[i], 16'h0000);
		end
		rd(fcc_pkg::OFS_CLKDIV, 16'h00bf);
		$display("reserved test done");
		wr(fcc_pkg::OFS_CONFIG, 16'h01e0);
		rd(fcc_pkg::OFS_CONFIG, 16'h01c0);
		backdoor_enable <= 1'b1;
		rd(fcc_pkg::OFS_SECHI, 16'h8000);
		// no core interrupts are modelled, so branch-in-place may be raised here
		wr(fcc_pkg::OFS_CONFIG, 16'h0121);
		rd(fcc_pkg::OFS_CONFIG, 16'h0121);
		access_error_flag <= 1'b1;
		command_buffer_empty_flag <= 1'b1;
		command_complete_flag <= 1'b1;
		irq(3'h4);
		arr_wr(2'h2);
		array_busy <= 1'b1;
		arr_rd(lfsr(), fcc_pkg::BRANCH_SELF_OPCODE);
		wr(fcc_pkg::OFS_CONFIG, 16'h00c2);
		irq(3'h3);
		arr_wr(2'h1);
		wr(fcc_pkg::OFS_CONFIG, 16'h0001);
		rd(fcc_pkg::OFS_CONFIG, 16'h0002);
		v1 = lfsr();
		arr_rd(v1, v1);
		irq(3'h0);
		array_busy <= 1'b0;
		v2 = lfsr();
		arr_rd(v2, v2);
		$display("config test done");
		v1 = lfsr();
		v2 = lfsr();
		wr(fcc_pkg::OFS_PROT, v1);
		rd(fcc_pkg::OFS_PROT, v1);
		wr(fcc_pkg::OFS_CONFIG, 16'h0400);
		wr(fcc_pkg::OFS_PROT, v2);
		rd(fcc_pkg::OFS_PROT, v1);
		chk("sector_protection", sector_protection, v1);
		wr(fcc_pkg::OFS_CONFIG, 16'h0000);
		rd(fcc_pkg::OFS_CONFIG, 16'h0402);
		test_mode <= 1'b1;
		wr(fcc_pkg::OFS_CONFIG, 16'h0000);
		rd(fcc_pkg::OFS_CONFIG, 16'h0002);
		wr(fcc_pkg::OFS_PROT, v2);
		rd(fcc_pkg::OFS_PROT, v2);
		chk("sector_protection", sector_protection, v2);
		$display("lock test done");
		repeat (3) @(posedge clk);
		end_sim();
	end
endmodule : fcc_flash_ctrl_tb
